// ---- ptx_pkg.sv ----
// ptx_pkg: shared constants for the phy transmit port and its mac-side driver
// assumes: both ends run on a 50 MHz ref_clk
package ptx_pkg;
  localparam int PTX_REF_CLK_KHZ = 50000;
  localparam int PTX_CLK_100_KHZ = 25000;
  localparam int PTX_CLK_10_KHZ = 2500;
  // half periods of the transmit clock in ref_clk cycles
  localparam int PTX_HALF_100 = PTX_REF_CLK_KHZ / (2 * PTX_CLK_100_KHZ);
  localparam int PTX_HALF_10 = PTX_REF_CLK_KHZ / (2 * PTX_CLK_10_KHZ);
  localparam int PTX_DIV_W = 5;
  localparam int PTX_FIFO_DEPTH = 8;
  localparam int PTX_WORD_W = 7;
  localparam logic [4:0] PTX_CODE_HALT = 5'h04;
  localparam logic PTX_STRAP_MII = 1'b0;
  localparam logic PTX_STRAP_RMII = 1'b1;
  typedef enum logic {PTX_SPEED_10, PTX_SPEED_100} ptx_speed_t;
  function automatic logic [4:0] ptx_enc4b5b(input logic [3:0] n);
    case (n)
      4'h0: ptx_enc4b5b = 5'h1e;
      4'h1: ptx_enc4b5b = 5'h09;
      4'h2: ptx_enc4b5b = 5'h14;
      4'h3: ptx_enc4b5b = 5'h15;
      4'h4: ptx_enc4b5b = 5'h0a;
      4'h5: ptx_enc4b5b = 5'h0b;
      4'h6: ptx_enc4b5b = 5'h0e;
      4'h7: ptx_enc4b5b = 5'h0f;
      4'h8: ptx_enc4b5b = 5'h12;
      4'h9: ptx_enc4b5b = 5'h13;
      4'ha: ptx_enc4b5b = 5'h16;
      4'hb: ptx_enc4b5b = 5'h17;
      4'hc: ptx_enc4b5b = 5'h1a;
      4'hd: ptx_enc4b5b = 5'h1b;
      4'he: ptx_enc4b5b = 5'h1c;
      default: ptx_enc4b5b = 5'h1d;
    endcase
  endfunction
endpackage

// ---- ptx_if.sv ----
// ptx_if: mii/rmii transmit pins between mac and phy
// assumes: the bench resolves the shared error/interrupt pin from its enables
`timescale 1ns/100ps
interface ptx_if;
  logic tx_clk;
  logic tx_en;
  logic [3:0] txd;
  logic tx_er_o;
  logic tx_er_oe;
  logic irq_n_o;
  logic irq_n_oe;
  logic tx_er_pin;
  modport phy
  (
    input tx_en, txd, tx_er_pin,
    output tx_clk, irq_n_o, irq_n_oe
  );
  modport mac
  (
    input tx_clk, tx_er_pin,
    output tx_en, txd, tx_er_o, tx_er_oe
  );
endinterface

// ---- ptx_fifo.sv ----
// ptx_fifo: small synchronous fifo with valid/ready on both sides
// assumes: one clock for both sides
`timescale 1ns/100ps
module ptx_fifo #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 8
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];
  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ---- ptx_phy.sv ----
// ptx_phy: phy end of the transmit port; makes tx_clk in mii mode, samples mac data,
// encodes 4b/5b into a fifo toward the line side; in rmii mode pushes raw dibits
// assumes: mac pins arrive asynchronously; straps are stable at reset release
`timescale 1ns/100ps
module ptx_phy
  import ptx_pkg::*;
#(
  parameter int FIFO_DEPTH = PTX_FIFO_DEPTH
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  ptx_if.phy pins,
  input wire logic reduced_interface_select_strap,
  input wire logic interrupt_pin_select_strap,
  input wire logic speed_100,
  input wire logic symbol_mode,
  input wire logic irq_req,
  output logic rmii_mode,
  output logic irq_mode,
  output logic sym_valid,
  input wire logic sym_ready,
  output logic [4:0] sym_data,
  output logic sym_err,
  output logic sym_last,
  output logic overflow
);
  // ----------------------------------------------------------------
  // strap capture after reset release
  // ----------------------------------------------------------------
  // straps settle through two flops while reset is held, so capture reads a
  // clean level at the first edge after release
  logic [1:0] strap_s1;
  logic [1:0] strap_s2;
  always_ff @(posedge ref_clk)
  begin
    strap_s1 <= {interrupt_pin_select_strap, reduced_interface_select_strap};
    strap_s2 <= strap_s1;
  end
  logic straps_taken;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      straps_taken <= 1'b0;
      rmii_mode <= 1'b0;
      irq_mode <= 1'b0;
    end
    else if (!straps_taken)
    begin
      straps_taken <= 1'b1;
      rmii_mode <= (strap_s2[0] == PTX_STRAP_RMII);
      irq_mode <= strap_s2[1];
    end
  end
  // ----------------------------------------------------------------
  // transmit clock divider
  // ----------------------------------------------------------------
  logic [PTX_DIV_W-1:0] div_cnt;
  logic clk_out;
  logic [PTX_DIV_W-1:0] half;
  assign half = speed_100 ? PTX_DIV_W'(PTX_HALF_100 - 1) : PTX_DIV_W'(PTX_HALF_10 - 1);
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_cnt <= '0;
      clk_out <= 1'b0;
    end
    else if (div_cnt >= half)
    begin
      div_cnt <= '0;
      clk_out <= !clk_out;
    end
    else
    begin
      div_cnt <= div_cnt + 1'b1;
    end
  end
  assign pins.tx_clk = rmii_mode ? 1'b0 : clk_out;
  // rising edge of our own clock; mac changes pins on it, so sample on next rise
  logic rise;
  assign rise = (div_cnt >= half) && !clk_out;
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [5:0] sync1;
  logic [5:0] sync2;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= {pins.tx_er_pin, pins.tx_en, pins.txd};
      sync2 <= sync1;
    end
  end
  // ----------------------------------------------------------------
  // sampling and encoding
  // ----------------------------------------------------------------
  logic s_en;
  logic s_er;
  logic [3:0] s_d;
  logic er_used;
  logic was_en;
  logic take;
  logic [PTX_WORD_W-1:0] word;
  logic fifo_ready;
  assign s_d = sync2[3:0];
  assign s_en = sync2[4];
  assign s_er = sync2[5];
  // at 10 mbps the pin is dropped in every role, symbol mode included
  assign er_used = !rmii_mode && !irq_mode && speed_100 && s_er;
  assign take = rmii_mode ? 1'b1 : rise;
  always_comb
  begin
    word = '0;
    if (rmii_mode)
    begin
      word = {2'b00, 3'b000, s_d[1:0]};
    end
    else if (symbol_mode)
    begin
      word = {2'b00, er_used, s_d};
    end
    else if (er_used && speed_100)
    begin
      word = {2'b01, PTX_CODE_HALT};
    end
    else
    begin
      word = {2'b00, ptx_enc4b5b(s_d)};
    end
  end
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      was_en <= 1'b0;
      overflow <= 1'b0;
    end
    else if (take && straps_taken)
    begin
      was_en <= s_en;
      if (s_en && !fifo_ready)
      begin
        overflow <= 1'b1;
      end
    end
  end
  logic push_valid;
  logic [PTX_WORD_W-1:0] push_word;
  // end of frame pushes a marker word carrying only the last flag
  assign push_valid = take && straps_taken && (s_en || was_en);
  assign push_word = s_en ? word : {1'b1, 6'h00};
  logic [PTX_WORD_W-1:0] out_word;
  ptx_fifo #(.WIDTH(PTX_WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo
  (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .in_valid(push_valid),
    .in_ready(fifo_ready),
    .in_data(push_word),
    .out_valid(sym_valid),
    .out_ready(sym_ready),
    .out_data(out_word)
  );
  assign sym_data = out_word[4:0];
  assign sym_err = out_word[5];
  assign sym_last = out_word[6];
  // ----------------------------------------------------------------
  // interrupt output on the shared pin
  // ----------------------------------------------------------------
  logic irq_q;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= irq_req;
    end
  end
  // open drain: drive low only, external pull-up gives the high level
  assign pins.irq_n_o = 1'b0;
  assign pins.irq_n_oe = irq_mode && irq_q;
endmodule

// ---- ptx_mac.sv ----
// ptx_mac: mac end of the transmit port; drives nibbles on tx_clk
// assumes: in rmii mode the mac is paced by ref_clk itself
`timescale 1ns/100ps
module ptx_mac
  import ptx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  ptx_if.mac pins,
  input wire logic rmii_mode,
  input wire logic err_pin_drive,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [3:0] in_data,
  input wire logic in_err,
  input wire logic in_last
);
  logic c1;
  logic c2;
  logic c3;
  logic step;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      c1 <= 1'b0;
      c2 <= 1'b0;
      c3 <= 1'b0;
    end
    else
    begin
      c1 <= pins.tx_clk;
      c2 <= c1;
      c3 <= c2;
    end
  end
  assign step = rmii_mode ? 1'b1 : (c2 && !c3);
  assign in_ready = step;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pins.tx_en <= 1'b0;
      pins.txd <= 4'h0;
      pins.tx_er_o <= 1'b0;
    end
    else if (step)
    begin
      pins.tx_en <= in_valid;
      pins.txd <= in_valid ? (rmii_mode ? {2'b00, in_data[1:0]} : in_data) : 4'h0;
      pins.tx_er_o <= in_valid && in_err && !rmii_mode;
    end
  end
  assign pins.tx_er_oe = err_pin_drive;
endmodule

// ---- ptx_chk.sv ----
// ptx_chk: assertions on the transmit pins
// assumes: speed_100 changes only in reset
`timescale 1ns/100ps
module ptx_chk
  import ptx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic tx_clk,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  input wire logic irq_n_o,
  input wire logic irq_n_oe,
  input wire logic rmii_mode,
  input wire logic irq_mode,
  input wire logic speed_100,
  input wire logic irq_req
);
  logic clk_q;
  logic seen;
  logic [4:0] cnt;
  // length of the tx_clk phase that just ended
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      clk_q <= 1'b0;
      seen <= 1'b0;
      cnt <= 5'h00;
    end
    else
    begin
      clk_q <= tx_clk;
      seen <= seen | (tx_clk != clk_q);
      cnt <= (tx_clk != clk_q) ? 5'h01 : cnt + 5'h01;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  sequence fast_cyc;
    $fell(tx_clk) ##1 $rose(tx_clk);
  endsequence
  clk_half_a: assert property (
    seen && !rmii_mode && tx_clk != clk_q |-> cnt == (speed_100 ? PTX_HALF_100 : PTX_HALF_10))
    else $error("bad tx_clk half period");
  clk_fast_a: assert property (
    !rmii_mode && speed_100 && $rose(tx_clk) |=> fast_cyc) else $error("tx_clk not fast");
  clk_stop_a: assert property (
    rmii_mode && $past(rmii_mode, 2) |-> !tx_clk) else $error("tx_clk runs in rmii");
  pad_low_a: assert property (
    rmii_mode && $past(rmii_mode, 2) |-> txd[3:2] == 2'b00) else $error("txd high bits set");
  pin_step_a: assert property (
    $rose(tx_clk) |-> $stable({tx_en, txd})) else $error("pins move at rise");
  irq_low_a: assert property (
    irq_n_oe |-> !irq_n_o) else $error("interrupt drives high");
  irq_off_a: assert property (
    !irq_mode |-> !irq_n_oe) else $error("interrupt in data role");
  irq_fol_a: assert property (
    irq_mode && $past(irq_mode) |-> irq_n_oe == $past(irq_req)) else $error("interrupt lags");
endmodule

// ---- ptx_tb.sv ----
// ptx_tb: mac user side in, phy symbol side out
// assumes: pull-up on the shared error/interrupt pin
`timescale 1ns/100ps
module ptx_tb
  import ptx_pkg::*;
;
  logic ref_clk, rst_b, rm, irq, spd, sym, irq_req, in_valid, in_err, sym_ready;
  logic rmii_mode, irq_mode, in_ready, sym_valid, sym_err, sym_last, overflow;
  logic [3:0] in_data;
  logic [4:0] sym_data;
  int miscompares;
  int checked;
  int n;
  logic [4:0] enc [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  ptx_if bus();
  assign bus.tx_er_pin = bus.irq_n_oe ? 1'b0 : (bus.tx_er_oe ? bus.tx_er_o : 1'b1);
  ptx_phy i_ptx_phy (.ref_clk(ref_clk), .rst_b(rst_b), .pins(bus.phy),
    .reduced_interface_select_strap(rm), .interrupt_pin_select_strap(irq),
    .speed_100(spd), .symbol_mode(sym), .irq_req(irq_req), .rmii_mode(rmii_mode),
    .irq_mode(irq_mode), .sym_valid(sym_valid), .sym_ready(sym_ready),
    .sym_data(sym_data), .sym_err(sym_err), .sym_last(sym_last), .overflow(overflow));
  ptx_mac i_ptx_mac (.ref_clk(ref_clk), .rst_b(rst_b), .pins(bus.mac),
    .rmii_mode(rmii_mode), .err_pin_drive(!irq), .in_valid(in_valid),
    .in_ready(in_ready), .in_data(in_data), .in_err(in_err), .in_last(1'b0));
  ptx_chk i_ptx_chk (.ref_clk(ref_clk), .rst_b(rst_b), .tx_clk(bus.tx_clk),
    .tx_en(bus.tx_en), .txd(bus.txd), .irq_n_o(bus.irq_n_o), .irq_n_oe(bus.irq_n_oe),
    .rmii_mode(rmii_mode), .irq_mode(irq_mode), .speed_100(spd), .irq_req(irq_req));
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic final_report();
    if (miscompares == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic hung();
    miscompares++;
    final_report();
  endtask
  // request held until the edge that sees in_ready high
  task automatic send(input logic [3:0] d, input logic e);
    int i;
    in_valid = 1'b1;
    in_data = d;
    in_err = e;
    for (i = 0; i < 100 && in_ready !== 1'b1; i++)
      tick();
    if (i == 100)
      hung();
    tick();
  endtask
  task automatic get(input logic [6:0] e);
    int i;
    for (i = 0; i < 100 && sym_valid !== 1'b1; i++)
      tick();
    if (i == 100)
      hung();
    chk({1'b0, sym_last, sym_err, sym_data}, {1'b0, e});
    sym_ready = 1'b1;
    tick();
    sym_ready = 1'b0;
    tick();
  endtask
  // {last, err, code} expected for one nibble
  function automatic logic [6:0] word(input logic [3:0] d, input logic e);
    if (rm)
      return {5'h00, d[1:0]};
    if (sym)
      return {2'b00, e && spd && !irq, d};
    if (e && spd && !irq)
      return {2'b01, PTX_CODE_HALT};
    return {2'b00, enc[d]};
  endfunction
  task automatic frame(input logic [3:0] b, input int k, input int ep);
    int j;
    for (j = 0; j < k; j++)
      send(b + j[3:0], j == ep);
    in_valid = 1'b0;
    for (j = 0; j < k; j++)
      get(word(b + j[3:0], j == ep));
    get(7'h40);
  endtask
  task automatic cfg(input logic [3:0] c);
    rst_b = 1'b0;
    {rm, irq, spd, sym} = c;
    repeat (20)
      tick();
    rst_b = 1'b1;
    repeat (2)
      tick();
    chk({6'h00, rmii_mode, irq_mode}, {6'h00, rm, irq});
  endtask
  initial
  begin
    {rst_b, irq_req, in_valid, in_err, sym_ready, in_data} = 9'h000;
    {rm, irq, spd, sym} = 4'h0;
    miscompares = 0;
    checked = 0;
    cfg(4'h2);
    for (int f = 0; f < 4; f++)
      frame(4'(f * 4), 4, 9);
    frame(4'h3, 3, 1);
    cfg(4'h0);
    frame(4'h5, 3, 1);
    cfg(4'h3);
    frame(4'hc, 3, 1);
    cfg(4'ha);
    frame(4'hd, 4, 1);
    cfg(4'h6);
    frame(4'h7, 3, 0);
    irq_req = 1'b1;
    repeat (3)
      tick();
    chk({7'h00, bus.tx_er_pin}, 8'h00);
    irq_req = 1'b0;
    repeat (3)
      tick();
    chk({7'h00, bus.tx_er_pin}, 8'h01);
    cfg(4'h2);
    for (int f = 0; f < 10; f++)
      send(4'(f), 1'b0);
    in_valid = 1'b0;
    repeat (10)
      tick();
    chk({7'h00, overflow}, 8'h01);
    n = 0;
    sym_ready = 1'b1;
    for (int i = 0; i < 20; i++)
    begin
      n += (sym_valid === 1'b1);
      tick();
    end
    chk(8'(n), 8'h08);
    final_report();
  end
endmodule
